// >>> verilog/refine_pkg.sv
// Constants shared by the timing refinement control block and its prescaler.
// Assumes a single 100 MHz crystal clock and a synchronous active-high reset.
package refine_pkg;

    // ***************************************************************
    // Clock and timing
    // ***************************************************************
    localparam int CLK_PERIOD_NS     = 10;
    localparam int INT_DIS_MIN_NS    = 200;
    // Width must exceed the minimum, hence the extra cycle
    localparam int INT_DIS_CYC       = INT_DIS_MIN_NS / CLK_PERIOD_NS + 1;
    localparam int CMD_GAP_NS        = 100;
    localparam int CMD_GAP_CYC       =
        (CMD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LEGACY_DIS_TICKS  = 4;
    localparam int LEGACY_GAP_TICKS  = 2;
    localparam int SET_PULSE_TICKS   = 4;
    localparam int OS_BASE_DIV       = 5;
    localparam int TIMER_W           = 5;

    // ***************************************************************
    // Field layout and reset values
    // ***************************************************************
    localparam int STAT_TA_BIT       = 0;
    localparam int STAT_RI_BIT       = 2;
    localparam int REV_SEL_W         = 3;
    localparam logic       REFINE_RST = 1'b0;
    localparam logic       FLAG_RST   = 1'b1;
    localparam logic [7:0] MASK_RST   = 8'h00;
    localparam logic [7:0] BYTE_ZERO  = 8'h00;
    localparam logic [2:0] SEL_RST    = 3'h0;

    // ***************************************************************
    // Command codes
    // ***************************************************************
    localparam logic [1:0] CMD_CLEAR_TXRX_INT = 2'h0;
    localparam logic [1:0] CMD_CLEAR_FLAGS    = 2'h1;
    localparam logic [1:0] CMD_ENABLE_TX      = 2'h2;
    localparam logic [1:0] CMD_ENABLE_RX      = 2'h3;

endpackage

// >>> verilog/rate_prescaler.sv
// Rate prescaler producing the oversample clock as a one-cycle tick.
// Assumes the selection comes from host logic on the same crystal clock.
`timescale 1ns/1ps
`default_nettype none
module rate_prescaler #(
    parameter int BASE_DIV = refine_pkg::OS_BASE_DIV
) (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    // Control
    input  wire logic       i_refine,
    input  wire logic [2:0] i_select,
    // Oversample clock tick
    output logic            o_os_tick
);

    generate
        if (BASE_DIV < 2 || BASE_DIV > 511) begin : g_bad_div
            $error("BASE_DIV out of range");
        end
    endgenerate

    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic [2:0]  sel_s1;
    logic [2:0]  sel_s2;
    logic [2:0]  active_sel;
    logic [2:0]  next_active_sel;
    logic [2:0]  eff_sel;
    logic [15:0] limit;
    logic        wrap;

    always_comb begin
        // Legacy mode takes the raw selection, so a change may glitch
        eff_sel = i_refine ? active_sel : i_select; // RULE_06
        limit = (16'(BASE_DIV) << eff_sel) - 16'h0001; // RULE_05
        wrap = (cnt >= limit);
        next_cnt = wrap ? 16'h0000 : cnt + 16'h0001;
        next_active_sel = active_sel;
        if (wrap) begin
            next_active_sel = sel_s2; // RULE_06
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cnt        <= 16'h0000;
            sel_s1     <= refine_pkg::SEL_RST;
            sel_s2     <= refine_pkg::SEL_RST;
            active_sel <= refine_pkg::SEL_RST;
            o_os_tick  <= 1'b0;
        end else begin
            cnt        <= next_cnt;
            sel_s1     <= i_select; // RULE_18
            sel_s2     <= sel_s1; // RULE_18
            active_sel <= next_active_sel;
            o_os_tick  <= wrap;
        end
    end

endmodule // rate_prescaler
`default_nettype wire

// >>> verilog/timing_refinement_control.sv
// Timing refinement control: interrupt disable pulse, command write spacing,
// status flag setting, probe state clean-up, mask and soft reset handling.
// Assumes host strobes are one-cycle pulses on the crystal clock.
// Operation
// RULE_01: Refine bit resets zero; one enables all.
// RULE_02: Clear commands or next_station_id read drop interrupt.
// RULE_03: Legacy drop width follows oversample clock rate.
// RULE_04: Refined drop width always exceeds 200 ns.
// RULE_05: Prescale select field chooses prescaler output.
// RULE_06: Refined selection is synchronised, legacy direct.
// RULE_07: Host keeps select zero above 5 Mbps.
// RULE_08: Legacy command spacing counts oversample ticks.
// RULE_09: Refined command spacing is fixed 100 ns.
// RULE_10: Legacy flag return opens enable prohibition.
// RULE_11: Refined flags return at pulse end.
// RULE_12: Receive-inhibited return raises the interrupt.
// RULE_13: Refined ID writes clear probe state.
// RULE_14: Refined soft reset also clears mask.
// RULE_15: Own ID zero or reset bit: soft reset.
// RULE_16: Soft reset sets both status flags.
// RULE_17: Revision check readback on registers five, six.
// RULE_18: Two-stage selection synchroniser per bit.
// RULE_19: Refine bit host-writable, cleared by hard reset.
`timescale 1ns/1ps
`default_nettype none
module timing_refinement_control (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    // Configuration and setup writes
    input  wire logic       i_cfg_wr,
    input  wire logic       i_cfg_timing_refine_enable,
    input  wire logic       i_cfg_reset_bit,
    input  wire logic       i_setup_wr,
    input  wire logic [2:0] i_setup_clock_prescale_select,
    // Command register
    input  wire logic       i_cmd_wr,
    input  wire logic [1:0] i_cmd_op,
    output logic            o_cmd_ready,
    output logic            o_cmd_accept,
    output logic [1:0]      o_cmd_op,
    // Station ID registers
    input  wire logic       i_own_id_wr,
    input  wire logic       i_probe_id_wr,
    input  wire logic [7:0] i_id_data,
    input  wire logic       i_next_station_id_rd,
    // Protocol engine events
    input  wire logic       i_tx_done,
    input  wire logic       i_rx_done,
    input  wire logic       i_probe_seen,
    input  wire logic       i_dup_seen,
    input  wire logic [7:0] i_status_ext,
    // Mask register
    input  wire logic       i_mask_wr,
    input  wire logic [7:0] i_mask_data,
    // Revision check registers
    input  wire logic       i_rev5_wr,
    input  wire logic       i_rev6_wr,
    input  wire logic [7:0] i_rev_data,
    output logic [7:0]      o_rev5_rdata,
    output logic [7:0]      o_rev6_rdata,
    // State outputs
    output logic            o_timing_refine_enable,
    output logic [2:0]      o_clock_prescale_select,
    output logic            o_oversample_clock,
    output logic            o_soft_reset,
    output logic            o_tx_available_flag,
    output logic            o_rx_inhibited_flag,
    output logic            o_enable_prohibited,
    output logic [7:0]      o_status,
    output logic [7:0]      o_mask,
    output logic [7:0]      o_own_station_id,
    output logic            o_probe_station_hit,
    output logic            o_duplicate_station_hit,
    output logic            o_interrupt_request_n
);

    // ***************************************************************
    // Configuration, IDs, soft reset, revision registers
    // ***************************************************************
    logic       refine;
    logic       next_refine;
    logic       cfg_reset;
    logic       next_cfg_reset;
    logic [2:0] prescale_sel;
    logic [2:0] next_prescale_sel;
    logic [7:0] own_id;
    logic [7:0] next_own_id;
    logic       own_zero_d;
    logic       soft_rst;
    logic       next_soft_rst;
    logic [7:0] mask;
    logic [7:0] next_mask;
    logic [7:0] rev5;
    logic [7:0] next_rev5;
    logic [7:0] rev6;
    logic [7:0] next_rev6;
    logic       os_tick;

    always_comb begin
        next_refine = refine;
        next_cfg_reset = cfg_reset;
        if (i_cfg_wr) begin
            next_refine = i_cfg_timing_refine_enable; // RULE_19
            next_cfg_reset = i_cfg_reset_bit;
        end
        next_prescale_sel = i_setup_wr ? i_setup_clock_prescale_select
                                       : prescale_sel;
        next_own_id = i_own_id_wr ? i_id_data : own_id;
        // Pulse on own ID becoming zero or reset bit rising
        next_soft_rst = ((own_id == refine_pkg::BYTE_ZERO) && !own_zero_d)
                      || (next_cfg_reset && !cfg_reset); // RULE_15
        next_mask = mask;
        if (soft_rst && refine) begin
            next_mask = refine_pkg::MASK_RST; // RULE_14
        end
        if (i_mask_wr) begin
            next_mask = i_mask_data;
        end
        next_rev5 = i_rev5_wr ? i_rev_data : rev5;
        next_rev6 = i_rev6_wr ? i_rev_data : rev6;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            refine       <= refine_pkg::REFINE_RST; // RULE_01
            cfg_reset    <= 1'b0;
            prescale_sel <= refine_pkg::SEL_RST;
            own_id       <= refine_pkg::BYTE_ZERO;
            own_zero_d   <= 1'b1;
            soft_rst     <= 1'b0;
            mask         <= refine_pkg::MASK_RST; // RULE_14
            rev5         <= refine_pkg::BYTE_ZERO;
            rev6         <= refine_pkg::BYTE_ZERO;
        end else begin
            refine       <= next_refine;
            cfg_reset    <= next_cfg_reset;
            prescale_sel <= next_prescale_sel;
            own_id       <= next_own_id;
            own_zero_d   <= (own_id == refine_pkg::BYTE_ZERO);
            soft_rst     <= next_soft_rst;
            mask         <= next_mask;
            rev5         <= next_rev5;
            rev6         <= next_rev6;
        end
    end

    rate_prescaler #(
        .BASE_DIV (refine_pkg::OS_BASE_DIV)
    ) u_prescaler (
        .i_mclk    (i_mclk),
        .i_rst     (i_rst),
        .i_refine  (refine), // RULE_06
        .i_select  (prescale_sel), // RULE_05
        .o_os_tick (os_tick)
    );

    // ***************************************************************
    // Command write spacing
    // ***************************************************************
    logic [refine_pkg::TIMER_W-1:0] gap_cnt;
    logic [refine_pkg::TIMER_W-1:0] next_gap_cnt;
    logic                           gap_fixed;
    logic                           next_gap_fixed;
    logic                           prohibit;
    logic                           cmd_take;
    logic                           is_enable;
    logic                           next_cmd_accept;

    always_comb begin
        is_enable = (i_cmd_op == refine_pkg::CMD_ENABLE_TX)
                 || (i_cmd_op == refine_pkg::CMD_ENABLE_RX);
        // Enables written inside the legacy window are dropped silently
        cmd_take = i_cmd_wr && (gap_cnt == '0)
                && !(is_enable && prohibit); // RULE_10
        next_cmd_accept = cmd_take;
        next_gap_cnt = gap_cnt;
        next_gap_fixed = gap_fixed;
        if (cmd_take) begin
            next_gap_fixed = refine;
            if (refine) begin
                next_gap_cnt = refine_pkg::TIMER_W'(
                    refine_pkg::CMD_GAP_CYC - 1); // RULE_09
            end else begin
                // One extra tick, since the first may come at once
                next_gap_cnt = refine_pkg::TIMER_W'(
                    refine_pkg::LEGACY_GAP_TICKS + 1); // RULE_08
            end
        end else if (gap_cnt != '0 && (gap_fixed || os_tick)) begin
            next_gap_cnt = gap_cnt - 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            gap_cnt      <= '0;
            gap_fixed    <= 1'b0;
            o_cmd_accept <= 1'b0;
            o_cmd_op     <= refine_pkg::CMD_CLEAR_TXRX_INT;
        end else begin
            gap_cnt      <= next_gap_cnt;
            gap_fixed    <= next_gap_fixed;
            o_cmd_accept <= next_cmd_accept;
            o_cmd_op     <= cmd_take ? i_cmd_op : o_cmd_op;
        end
    end

    // ***************************************************************
    // Status flag setting pulses (0: transmitter, 1: receiver)
    // ***************************************************************
    typedef enum logic {PULSE_IDLE, PULSE_RUN} pulse_e;

    logic [1:0] flag;
    logic [1:0] win;
    logic [1:0] set_evt;
    logic [1:0] clr_evt;

    assign set_evt = {i_rx_done, i_tx_done};
    assign clr_evt = {cmd_take && i_cmd_op == refine_pkg::CMD_ENABLE_RX,
                      cmd_take && i_cmd_op == refine_pkg::CMD_ENABLE_TX};

    generate
        for (genvar g = 0; g < 2; g++) begin : g_flag
            pulse_e                         st;
            pulse_e                         next_st;
            logic [refine_pkg::TIMER_W-1:0] cnt;
            logic [refine_pkg::TIMER_W-1:0] next_cnt;
            logic                           late;
            logic                           next_late;
            logic                           fl;
            logic                           next_fl;

            always_comb begin
                next_st = st;
                next_cnt = cnt;
                next_late = late;
                next_fl = clr_evt[g] ? 1'b0 : fl;
                case (st)
                    PULSE_IDLE: begin
                        if (set_evt[g]) begin
                            next_st = PULSE_RUN;
                            next_late = refine;
                            next_cnt = refine_pkg::TIMER_W'(
                                refine_pkg::SET_PULSE_TICKS);
                            if (!refine) begin
                                next_fl = 1'b1; // RULE_10
                            end
                        end
                    end
                    PULSE_RUN: begin
                        if (os_tick) begin
                            next_cnt = cnt - 1'b1;
                        end
                        if (os_tick && cnt == 1) begin
                            next_st = PULSE_IDLE;
                            if (late) begin
                                next_fl = 1'b1; // RULE_11
                            end
                        end
                    end
                    default: begin
                        next_st = PULSE_IDLE;
                    end
                endcase
                if (soft_rst) begin
                    next_st = PULSE_IDLE;
                    next_fl = refine_pkg::FLAG_RST; // RULE_16
                end
            end

            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    st   <= PULSE_IDLE;
                    cnt  <= '0;
                    late <= 1'b0;
                    fl   <= refine_pkg::FLAG_RST;
                end else begin
                    st   <= next_st;
                    cnt  <= next_cnt;
                    late <= next_late;
                    fl   <= next_fl;
                end
            end

            assign flag[g] = fl;
            // Refined pulses leave the flag unchanged until the pulse end instead of opening a window
            assign win[g] = (st == PULSE_RUN) && !late; // RULE_10
        end
    endgenerate

    assign prohibit = |win;

    // ***************************************************************
    // Interrupt and disable pulse
    // ***************************************************************
    logic [7:0]                     status;
    logic [refine_pkg::TIMER_W-1:0] dis_cnt;
    logic [refine_pkg::TIMER_W-1:0] next_dis_cnt;
    logic                           dis_fixed;
    logic                           next_dis_fixed;
    logic                           int_level;
    logic                           dis_trig;
    logic                           next_int_n;

    always_comb begin
        status = i_status_ext;
        status[refine_pkg::STAT_TA_BIT] = flag[0];
        status[refine_pkg::STAT_RI_BIT] = flag[1];
        int_level = |(status & mask); // RULE_12
        dis_trig = !o_interrupt_request_n && (i_next_station_id_rd
            || (cmd_take && (i_cmd_op == refine_pkg::CMD_CLEAR_TXRX_INT
                || i_cmd_op == refine_pkg::CMD_CLEAR_FLAGS))); // RULE_02
        next_dis_cnt = dis_cnt;
        next_dis_fixed = dis_fixed;
        if (dis_trig) begin
            next_dis_fixed = refine;
            if (refine) begin
                next_dis_cnt = refine_pkg::TIMER_W'(
                    refine_pkg::INT_DIS_CYC); // RULE_04
            end else begin
                // Width scales with the rate, too short at high rates
                next_dis_cnt = refine_pkg::TIMER_W'(
                    refine_pkg::LEGACY_DIS_TICKS + 1); // RULE_03
            end
        end else if (dis_cnt != '0 && (dis_fixed || os_tick)) begin
            next_dis_cnt = dis_cnt - 1'b1;
        end
        next_int_n = !(int_level && next_dis_cnt == '0); // RULE_02
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            dis_cnt               <= '0;
            dis_fixed             <= 1'b0;
            o_interrupt_request_n <= 1'b1;
        end else begin
            dis_cnt               <= next_dis_cnt;
            dis_fixed             <= next_dis_fixed;
            o_interrupt_request_n <= next_int_n;
        end
    end

    // ***************************************************************
    // Probe and duplicate station ID state
    // ***************************************************************
    logic probe_hit;
    logic next_probe_hit;
    logic dup_hit;
    logic next_dup_hit;
    logic id_flush;

    always_comb begin
        // Legacy mode leaves stale results set until a hard reset, since the engine can only set them
        id_flush = refine && (i_probe_id_wr || i_own_id_wr); // RULE_13
        next_probe_hit = i_probe_seen || (probe_hit && !id_flush);
        next_dup_hit = i_dup_seen || (dup_hit && !id_flush);
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            probe_hit <= 1'b0;
            dup_hit   <= 1'b0;
        end else begin
            probe_hit <= next_probe_hit;
            dup_hit   <= next_dup_hit;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    assign o_cmd_ready             = (gap_cnt == '0);
    assign o_timing_refine_enable  = refine;
    assign o_clock_prescale_select = prescale_sel;
    assign o_oversample_clock      = os_tick;
    assign o_soft_reset            = soft_rst;
    assign o_tx_available_flag     = flag[0];
    assign o_rx_inhibited_flag     = flag[1];
    assign o_enable_prohibited     = prohibit;
    assign o_status                = status;
    assign o_mask                  = mask;
    assign o_own_station_id        = own_id;
    assign o_probe_station_hit     = probe_hit;
    assign o_duplicate_station_hit = dup_hit;
    assign o_rev5_rdata            = rev5; // RULE_17
    // Low bits of register six reflect the selection held in five
    assign o_rev6_rdata = {rev6[7:refine_pkg::REV_SEL_W],
                           rev5[refine_pkg::REV_SEL_W-1:0]}; // RULE_17

endmodule // timing_refinement_control
`default_nettype wire

// >>> test/refine_checker_asserts.sv
// Checker for the timing refinement control block's port behaviour.
// Assumes one 100 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module refine_checker (
    // Clock and reset
    input wire logic       i_mclk,
    input wire logic       i_rst,
    // Watched ports
    input wire logic       i_cmd_wr,
    input wire logic [1:0] i_cmd_op,
    input wire logic       i_next_station_id_rd,
    input wire logic       i_rx_done,
    input wire logic       o_cmd_ready,
    input wire logic       o_cmd_accept,
    input wire logic [1:0] o_cmd_op,
    input wire logic       o_timing_refine_enable,
    input wire logic       o_soft_reset,
    input wire logic       o_tx_available_flag,
    input wire logic       o_rx_inhibited_flag,
    input wire logic       o_enable_prohibited,
    input wire logic [7:0] o_mask,
    input wire logic [7:0] o_own_station_id,
    input wire logic       o_interrupt_request_n
);
    // ***********************************
    // Properties
    // ***********************************
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    logic clr_take;
    // Enable ops have bit one set; only clears and next_station_id reads count
    assign clr_take = i_next_station_id_rd
        || (i_cmd_wr && o_cmd_ready && !i_cmd_op[1]);

    refine_rst_a: assert property (disable iff (1'b0)
        i_rst |=> !o_timing_refine_enable && o_mask == 8'h00)
        else $error("hard reset left refine bit or mask set");
    cmd_take_a: assert property (
        i_cmd_wr && o_cmd_ready && !(i_cmd_op[1] && o_enable_prohibited)
        |=> o_cmd_accept && o_cmd_op == $past(i_cmd_op))
        else $error("ready command was not taken");
    cmd_gap_a: assert property (
        o_cmd_accept && o_timing_refine_enable
        |-> !o_cmd_ready [*8] ##2 o_cmd_ready)
        else $error("refined command spacing wrong");
    int_drop_a: assert property (
        clr_take && !o_interrupt_request_n && o_timing_refine_enable
        |=> o_interrupt_request_n [*8])
        else $error("interrupt drop too short");
    legacy_prohib_a: assert property (
        i_rx_done && !o_timing_refine_enable
        |=> o_enable_prohibited && o_rx_inhibited_flag)
        else $error("legacy prohibition did not open");
    refine_prohib_a: assert property (
        $stable(o_timing_refine_enable) && o_timing_refine_enable
        |-> !o_enable_prohibited)
        else $error("prohibition seen with refine set");
    own_zero_a: assert property (
        $changed(o_own_station_id) && o_own_station_id == 8'h00
        |=> o_soft_reset)
        else $error("own id zero gave no soft reset");
    soft_flags_a: assert property (
        o_soft_reset |=> o_tx_available_flag && o_rx_inhibited_flag
        && (!o_timing_refine_enable || o_mask == 8'h00))
        else $error("soft reset left flags or mask");
endmodule // refine_checker
bind timing_refinement_control refine_checker u_check (.*);
`default_nettype wire

// >>> test/host_model.sv
// Host model: one-cycle register strobes with shared write data.
// Assumes the bench maps each strobe index to one block write input, and index 8 to the next_station_id read strobe.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic       i_mclk,
    // Strobes and data
    output logic [8:0]      o_wr,
    output logic [7:0]      o_data
);
    // ***********************************
    // Strobes
    // ***********************************
    initial o_wr = 9'h000;
    initial o_data = 8'h00;
    // Select changes stay at rates of 5 Mbps or less
    task automatic put(input int idx, input logic [7:0] d);
        @(negedge i_mclk);
        o_wr <= 9'h001 << idx;
        o_data <= d;
        @(negedge i_mclk);
        o_wr <= 9'h000;
    endtask
endmodule // host_model
`default_nettype wire

// >>> test/timing_refinement_control_tb.sv
// Self-checking bench for the timing refinement control block.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module timing_refinement_control_tb;
    // ***********************************
    // Bench
    // ***********************************
    // Arbitrary revision probe values, made up for this bench
    localparam logic [7:0] REV_PROBE = 8'h5C;
    localparam logic [7:0] REV_SEL   = 8'h03;
    localparam logic [7:0] REV_TOP   = 8'hC3;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] ev = 4'h0;
    logic [7:0] seed = 8'h4D;
    logic       sr_seen = 1'b0;
    int         n_errors = 0, num_checks = 0, n;
    logic [7:0] op_q[$];
    logic [7:0] mask_q[$];
    logic [8:0] wr;
    logic [7:0] data, rev5, rev6, mask, e, st;
    logic [1:0] opo;
    logic [2:0] sel_o;
    logic       ready, acc, refine, os, srst, ta, ri, proh, phit, dhit, irq_n;

    always #5 clk = ~clk;

    host_model host (.i_mclk(clk), .o_wr(wr), .o_data(data));
    timing_refinement_control dut (
        .i_mclk(clk), .i_rst(rst), .i_cfg_wr(wr[0]),
        .i_cfg_timing_refine_enable(data[0]), .i_cfg_reset_bit(data[1]),
        .i_setup_wr(wr[1]), .i_setup_clock_prescale_select(data[2:0]),
        .i_cmd_wr(wr[2]), .i_cmd_op(data[1:0]), .o_cmd_ready(ready),
        .o_cmd_accept(acc), .o_cmd_op(opo), .i_own_id_wr(wr[3]),
        .i_probe_id_wr(wr[4]), .i_id_data(data), .i_next_station_id_rd(wr[8]),
        .i_tx_done(ev[0]), .i_rx_done(ev[1]), .i_probe_seen(ev[2]),
        .i_dup_seen(ev[3]), .i_status_ext(8'h00), .i_mask_wr(wr[5]),
        .i_mask_data(data), .i_rev5_wr(wr[6]), .i_rev6_wr(wr[7]),
        .i_rev_data(data), .o_rev5_rdata(rev5), .o_rev6_rdata(rev6),
        .o_timing_refine_enable(refine), .o_clock_prescale_select(sel_o),
        .o_oversample_clock(os), .o_soft_reset(srst),
        .o_tx_available_flag(ta), .o_rx_inhibited_flag(ri),
        .o_enable_prohibited(proh), .o_status(st), .o_mask(mask),
        .o_own_station_id(), .o_probe_station_hit(phit),
        .o_duplicate_station_hit(dhit), .o_interrupt_request_n(irq_n));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (n_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wait_val(ref logic s, input logic v, output int cnt);
        for (cnt = 0; s !== v; cnt++) begin
            if (cnt == 2000) begin
                n_errors++;
                stop_test();
            end
            @(negedge clk);
        end
    endtask
    task automatic cmd(input logic [1:0] op, input logic taken);
        wait_val(ready, 1'b1, n);
        if (taken)
            op_q.push_back({6'h00, op});
        host.put(2, {6'h00, op});
    endtask

    // Results land on a rising edge; look half a cycle later
    always @(negedge clk) begin
        if (acc === 1'b1) begin
            e = op_q.size() > 0 ? op_q.pop_front() : 8'hFF;
            cmp({6'h00, opo}, e);
        end
        if (sr_seen)
            cmp(mask, mask_q.pop_front());
        sr_seen = (srst === 1'b1);
    end

    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        cmp({6'h00, ri, ta}, 8'h03);
        cmp({7'h00, refine}, 8'h00);
        seed = lfsr(seed);
        host.put(5, seed);
        cmp(mask, seed);
        @(negedge clk) ev = 4'h2;
        @(negedge clk) ev = 4'h0;
        cmp({7'h00, proh}, 8'h01);
        cmd(refine_pkg::CMD_ENABLE_RX, 1'b0);
        wait_val(proh, 1'b0, n);
        cmd(refine_pkg::CMD_CLEAR_TXRX_INT, 1'b1);
        host.put(2, 8'h01);
        wait_val(irq_n, 1'b0, n);
        cmp(8'(n + 2 >= 20), 8'h01);
        mask_q.push_back(seed);
        host.put(0, 8'h02);
        // Let the legacy soft reset finish before refine changes
        repeat (4) @(negedge clk);
        host.put(0, 8'h01);
        cmp({7'h00, refine}, 8'h01);
        for (int k = 0; k < 4; k++) begin
            cmd(2'(k), 1'b1);
            host.put(2, 8'(k));
        end
        host.put(5, 8'h01 << refine_pkg::STAT_RI_BIT);
        @(negedge clk) ev = 4'h2;
        @(negedge clk) ev = 4'h0;
        for (int k = 0; k < 3; k++) begin
            wait_val(irq_n, 1'b0, n);
            cmp(st, 8'h01 << refine_pkg::STAT_RI_BIT);
            if (k < 2)
                cmd(2'(k), 1'b1);
            else
                host.put(8, 8'h00);
            wait_val(irq_n, 1'b0, n);
            cmp(8'(n > 20), 8'h01);
        end
        @(negedge clk) ev = 4'hC;
        @(negedge clk) ev = 4'h0;
        cmp({6'h00, dhit, phit}, 8'h03);
        host.put(4, seed);
        cmp({6'h00, dhit, phit}, 8'h00);
        host.put(3, 8'h12);
        host.put(5, seed);
        mask_q.push_back(8'h00);
        host.put(3, 8'h00);
        repeat (4) @(negedge clk);
        host.put(7, REV_PROBE);
        host.put(6, REV_SEL);
        cmp(rev6, {REV_PROBE[7:3], REV_SEL[2:0]});
        host.put(6, REV_TOP);
        cmp(rev5, REV_TOP);
        host.put(1, 8'h02);
        cmp({5'h00, sel_o}, 8'h02);
        for (int k = 0; k < 3; k++) begin
            wait_val(os, 1'b1, n);
            wait_val(os, 1'b0, n);
            wait_val(os, 1'b1, n);
        end
        cmp(8'(n + 1), 8'(refine_pkg::OS_BASE_DIV << 2));
        cmp(8'(mask_q.size()), 8'h00);
        stop_test();
    end
endmodule // timing_refinement_control_tb
`default_nettype wire
